// File: iwr_asserts.sv
/*
 * Port checker for the watchdog core.
 * Assumes the dedicated clock is no faster than core_clk/4, with a ratio up to 256.
 */
`timescale 1ns/10ps
module iwr_asserts (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input iwr_pkg::iwr_cfg_t cfg,
   input wire logic refresh_cmd,
   input wire logic status_read_command,
   input wire logic clr_refresh_error,
   input wire logic clr_underflow,
   input wire logic [15:0] status_word,
   input wire logic status_valid,
   input wire logic counting,
   input wire logic refresh_busy,
   input wire logic irq,
   input wire logic wd_reset
);
   import iwr_pkg::*;
   // Generous, because a slow dedicated clock stretches the four-tick reload.
   localparam int BUSY_MAX = 10240;
   int busy_len; // Cycles the current reload has been pending.
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Counts how long a reload stays pending.
   always_ff @(posedge core_clk) begin
      if (!nrst || !refresh_busy) begin
         busy_len <= 0;
      end else begin
         busy_len <= busy_len + 1;
      end
   end
   sequence s_req;
      refresh_cmd && clk_en && !refresh_busy;
   endsequence
   sequence s_done;
      refresh_busy ##1 !refresh_busy;
   endsequence
   a_busy_start: assert property (s_req |=> refresh_busy)
      else $error("refresh did not become pending");
   a_busy_bound: assert property (busy_len < BUSY_MAX)
      else $error("reload pending too long");
   a_reload_run: assert property (s_done |-> counting)
      else $error("counter stopped after reload");
   a_start_cause: assert property ($rose(counting)
      |-> cfg.auto_start || $past(refresh_busy))
      else $error("counter started without refresh");
   a_read_valid: assert property (status_read_command && clk_en |=> status_valid)
      else $error("status not returned");
   a_valid_cause: assert property (status_valid |-> $past(status_read_command))
      else $error("status valid without read");
   a_stopped_full: assert property (status_valid && !counting
      && !$past(counting, 2) |-> status_word[13:0] == CNT_START)
      else $error("stopped counter not at start");
   a_irq_cause: assert property ($rose(irq) |-> $past(cfg.irq_en))
      else $error("interrupt while disabled");
   a_irq_drop: assert property ($fell(irq)
      |-> $past(clr_refresh_error, 2) || $past(clr_underflow, 2) || $past(clr_refresh_error)
      || $past(clr_underflow) || !$past(cfg.irq_en))
      else $error("flag dropped without clear");
   a_reset_pulse: assert property (wd_reset |-> !$past(cfg.irq_en) ##1 !wd_reset)
      else $error("reset pulse wrong");
endmodule
bind iwr_watchdog iwr_asserts iwr_asserts_inst (.core_clk, .nrst, .clk_en, .cfg, .refresh_cmd,
   .status_read_command, .clr_refresh_error, .clr_underflow, .status_word, .status_valid,
   .counting, .refresh_busy, .irq, .wd_reset);

// File: iwr_pkg.sv
/*
 * Package for the independent windowed watchdog: status layout, clock division
 * and window position encodings, reset values and timing counts.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package iwr_pkg;

   // Status word layout.
   localparam int unsigned STAT_REFERR_BIT = 15;
   localparam int unsigned STAT_UNDF_BIT = 14;
   localparam logic [15:0] STAT_REFERR_MASK = 16'h8000;
   localparam logic [15:0] STAT_UNDF_MASK = 16'h4000;
   localparam logic [15:0] STAT_COUNT_MASK = 16'h3FFF;
   localparam int unsigned CNT_W = 14;

   // Counter start value and reset values.
   localparam logic [13:0] CNT_START = 14'h3FFF;
   localparam logic [13:0] CNT_RESET = 14'h3FFF;

   // Count cycles a refresh needs before the reload takes effect.
   localparam logic [2:0] REFRESH_CYCLES = 3'h4;

   // Clock division ratio selector (field as written by software).
   localparam logic [7:0] DIV_1 = 8'h00;
   localparam logic [7:0] DIV_16 = 8'h20;
   localparam logic [7:0] DIV_32 = 8'h30;
   localparam logic [7:0] DIV_64 = 8'h40;
   localparam logic [7:0] DIV_128 = 8'hF0;
   localparam logic [7:0] DIV_256 = 8'h50;

   // Divider terminal counts; a count cycle lasts terminal+1 dedicated clock periods.
   localparam logic [7:0] DIV_LAST_1 = 8'h00;
   localparam logic [7:0] DIV_LAST_16 = 8'h0F;
   localparam logic [7:0] DIV_LAST_32 = 8'h1F;
   localparam logic [7:0] DIV_LAST_64 = 8'h3F;
   localparam logic [7:0] DIV_LAST_128 = 8'h7F;
   localparam logic [7:0] DIV_LAST_256 = 8'hFF;

   // Window start bounds as counter values; refresh is allowed at or below them.
   localparam logic [13:0] WIN_HI_25 = 14'h0FFF;
   localparam logic [13:0] WIN_HI_50 = 14'h1FFF;
   localparam logic [13:0] WIN_HI_75 = 14'h2FFF;
   localparam logic [13:0] WIN_HI_100 = 14'h3FFF;

   // Window end bounds as counter values; refresh is allowed at or above them.
   localparam logic [13:0] WIN_LO_75 = 14'h3000;
   localparam logic [13:0] WIN_LO_50 = 14'h2000;
   localparam logic [13:0] WIN_LO_25 = 14'h1000;
   localparam logic [13:0] WIN_LO_0 = 14'h0000;

   // Window end and start selectors.
   typedef enum logic [1:0] {
      WEND_75 = 2'b00,
      WEND_50 = 2'b01,
      WEND_25 = 2'b10,
      WEND_0 = 2'b11
   } iwr_wend_t;
   typedef enum logic [1:0] {
      WSTART_25 = 2'b00,
      WSTART_50 = 2'b01,
      WSTART_75 = 2'b10,
      WSTART_100 = 2'b11
   } iwr_wstart_t;

   // Configuration carried as one packed group.
   typedef struct packed {
      logic [7:0] clk_div;
      iwr_wend_t win_end;
      iwr_wstart_t win_start;
      logic irq_en;
      logic auto_start;
   } iwr_cfg_t;

   // Refresh sequencer states.
   typedef enum logic [1:0] {
      RS_IDLE = 2'b00,
      RS_WAIT = 2'b01,
      RS_LOAD = 2'b10
   } iwr_rstate_t;

endpackage

// File: iwr_prescaler.sv
/*
 * Prescaler for the watchdog: turns the synchronised dedicated clock into a
 * one-cycle count tick at the selected division ratio.
 * Assumes wd_clk_rise is a clean single-cycle pulse on core_clk.
 */
`timescale 1ns/10ps
module iwr_prescaler
   import iwr_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic wd_clk_rise,
   input wire logic [7:0] clk_div,
   output logic count_tick
);
   import iwr_pkg::*;

   logic [7:0] div_cnt_q; // Counts dedicated clock edges.
   logic [7:0] div_last; // Terminal value of the divider.

   // Decode the ratio; an unknown code falls back to no division.
   always_comb begin
      case (clk_div)
         DIV_16: div_last = DIV_LAST_16;
         DIV_32: div_last = DIV_LAST_32;
         DIV_64: div_last = DIV_LAST_64;
         DIV_128: div_last = DIV_LAST_128;
         DIV_256: div_last = DIV_LAST_256;
         default: div_last = DIV_LAST_1;
      endcase
   end

   // One count cycle spans div_last+1 dedicated clock periods.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         div_cnt_q <= 8'h00;
      end else if (clk_en && wd_clk_rise) begin
         div_cnt_q <= (div_cnt_q >= div_last) ? 8'h00 : div_cnt_q + 8'h01;
      end
   end

   assign count_tick = clk_en && wd_clk_rise && (div_cnt_q >= div_last);
endmodule

// File: iwr_watchdog.sv
/*
 * Independent windowed watchdog core: 14-bit down-counter, refresh window check,
 * sticky refresh error and underflow flags, status word and interrupt request.
 * Assumes core_clk is at least four times the undivided watchdog clock and that
 * the dedicated watchdog clock arrives asynchronously on a pin.
 */
// Overview of operation
// - Status bits 15,14 are error flags.
// - Status low 14 bits show live count.
// - Refresh reloads start value, counting continues.
// - Refresh outside window sets error flag.
// - Expiry without refresh sets underflow flag.
// - Refresh reload may take four count cycles.
// - Count cycle length follows division ratio.
// - Interrupt on underflow or refresh error.
// - Auto start runs counter right after reset.
// - Register start waits for first refresh.
// - Window end selects 75/50/25/0 percent.
// - Window start selects 25/50/75/100 percent.
`timescale 1ns/10ps
module iwr_watchdog
   import iwr_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic watchdog_dedicated_clock,
   input iwr_pkg::iwr_cfg_t cfg,
   input wire logic refresh_cmd,
   input wire logic status_read_command,
   input wire logic clr_refresh_error,
   input wire logic clr_underflow,
   output logic [15:0] status_word,
   output logic status_valid,
   output logic counting,
   output logic refresh_busy,
   output logic irq,
   output logic wd_reset
);
   import iwr_pkg::*;

   logic wdc_meta_q; // First synchroniser stage, read only by the second.
   logic wdc_sync_q; // Second synchroniser stage.
   logic wdc_prev_q; // Previous synchronised level for edge detect.
   logic wd_clk_rise; // One-cycle pulse per dedicated clock rising edge.
   logic count_tick; // One count cycle elapsed.
   logic [13:0] cnt_q; // The down-counter.
   logic run_q; // Counter is running.
   logic auto_q; // Auto start caught after reset release.
   logic started_q; // Auto start has been sampled once.
   logic refresh_error_flag; // Sticky refresh error.
   logic underflow_flag; // Sticky underflow.
   iwr_rstate_t rstate_q; // Refresh sequencer.
   logic [2:0] rwait_q; // Count cycles spent waiting for reload.
   logic in_window; // Counter inside refresh permitted window.
   logic [13:0] win_hi; // Start position as counter value (refresh allowed below).
   logic [13:0] win_lo; // End position as counter value (refresh allowed above).
   logic underflow_ev; // Counter passes zero on this tick.
   logic referr_ev; // Refresh attempted outside window.
   logic [15:0] status_q; // Registered status word.

   // Two-stage synchroniser for the asynchronous dedicated clock.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wdc_meta_q <= 1'b0;
         wdc_sync_q <= 1'b0;
         wdc_prev_q <= 1'b0;
      end else if (clk_en) begin
         wdc_meta_q <= watchdog_dedicated_clock;
         wdc_sync_q <= wdc_meta_q;
         wdc_prev_q <= wdc_sync_q;
      end
   end

   // The edge detector sees only the second stage and its delayed copy, never the metastable one.
   assign wd_clk_rise = wdc_sync_q && !wdc_prev_q;

   // The divider lives in its own module so the ratio decode stays local.
   iwr_prescaler iwr_prescaler_inst (
      .core_clk(core_clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .wd_clk_rise(wd_clk_rise),
      .clk_div(cfg.clk_div),
      .count_tick(count_tick)
   );

   // Window bounds as fractions of the full count, from quarter decodes.
   always_comb begin
      case (cfg.win_start)
         WSTART_25: win_hi = WIN_HI_25;
         WSTART_50: win_hi = WIN_HI_50;
         WSTART_75: win_hi = WIN_HI_75;
         default: win_hi = WIN_HI_100;
      endcase
      case (cfg.win_end)
         WEND_75: win_lo = WIN_LO_75;
         WEND_50: win_lo = WIN_LO_50;
         WEND_25: win_lo = WIN_LO_25;
         default: win_lo = WIN_LO_0;
      endcase
   end

   // Refresh is allowed once the count is at or below start and at or above end.
   // A stopped counter accepts any refresh, since that refresh starts it.
   assign in_window = !run_q || ((cnt_q <= win_hi) && (cnt_q >= win_lo));
   assign referr_ev = clk_en && refresh_cmd && !in_window;
   assign underflow_ev = run_q && count_tick && (cnt_q == 14'h0000)
      && (rstate_q != RS_LOAD);

   // Catch the auto start strap once after reset release.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         auto_q <= 1'b0;
         started_q <= 1'b0;
      end else if (clk_en && !started_q) begin
         auto_q <= cfg.auto_start;
         started_q <= 1'b1;
      end
   end

   // Refresh sequencer: wait for up to four count cycles, then reload.
   // Keeping the reload on a count boundary avoids a half-length first cycle.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rstate_q <= RS_IDLE;
         rwait_q <= 3'h0;
      end else if (clk_en) begin
         case (rstate_q)
            RS_IDLE: begin
               if (refresh_cmd) begin
                  rstate_q <= RS_WAIT;
                  rwait_q <= 3'h0;
               end
            end
            RS_WAIT: begin
               if (count_tick) begin
                  rwait_q <= rwait_q + 3'h1;
                  if (rwait_q + 3'h1 >= REFRESH_CYCLES - 3'h1) begin
                     rstate_q <= RS_LOAD;
                  end
               end
            end
            RS_LOAD: begin
               if (count_tick) begin
                  rstate_q <= RS_IDLE;
               end
            end
            default: rstate_q <= RS_IDLE;
         endcase
      end
   end

   // Down-counter: started by auto start or the first refresh, never by config.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cnt_q <= CNT_RESET;
         run_q <= 1'b0;
      end else if (clk_en) begin
         if (started_q && auto_q && !run_q) begin
            run_q <= 1'b1;
            cnt_q <= CNT_START;
         end else if (rstate_q == RS_LOAD && count_tick) begin
            run_q <= 1'b1;
            cnt_q <= CNT_START;
         end else if (run_q && count_tick) begin
            cnt_q <= cnt_q - 14'h0001;
         end
      end
   end

   // Sticky flags: a new event in the clearing cycle wins over the clear.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         refresh_error_flag <= 1'b0;
         underflow_flag <= 1'b0;
      end else if (clk_en) begin
         if (referr_ev) begin
            refresh_error_flag <= 1'b1;
         end else if (clr_refresh_error) begin
            refresh_error_flag <= 1'b0;
         end
         if (underflow_ev) begin
            underflow_flag <= 1'b1;
         end else if (clr_underflow) begin
            underflow_flag <= 1'b0;
         end
      end
   end

   // Status snapshot taken on a read command, one cycle later.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         status_q <= 16'h0000;
         status_valid <= 1'b0;
      end else if (clk_en) begin
         status_valid <= status_read_command;
         if (status_read_command) begin
            status_q <= (refresh_error_flag ? STAT_REFERR_MASK : 16'h0000)
               | (underflow_flag ? STAT_UNDF_MASK : 16'h0000)
               | ({2'b00, cnt_q} & STAT_COUNT_MASK);
         end
      end
   end

   // Interrupt or reset request: one output each, chosen by irq_en.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         irq <= 1'b0;
         wd_reset <= 1'b0;
      end else if (clk_en) begin
         irq <= cfg.irq_en && (refresh_error_flag || underflow_flag);
         wd_reset <= !cfg.irq_en && (referr_ev || underflow_ev);
      end
   end

   assign status_word = status_q;
   assign counting = run_q;
   assign refresh_busy = (rstate_q != RS_IDLE);

endmodule

// File: tb_top.sv
/*
 * Self-checking bench for the watchdog core.
 * Assumes the checker is bound in; clk_en is held high throughout.
 */
`timescale 1ns/10ps
module tb_top;
   import iwr_pkg::*;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic wd_clk = 1'b0; // Dedicated clock, a quarter of the core rate.
   logic [3:0] cmd = 4'h0; // Clear underflow, clear error, read, refresh.
   iwr_cfg_t cfg = '{DIV_1, WEND_0, WSTART_100, 1'b1, 1'b0};
   logic [15:0] status_word, a, b;
   logic status_valid, counting, refresh_busy, irq, wd_reset;
   int bad_count = 0;
   int compares = 0;
   int cyc = 0;
   int n;
   logic [7:0] divs [5] = '{DIV_16, DIV_32, DIV_64, DIV_128, DIV_256};
   int ratio [5] = '{16, 32, 64, 128, 256};
   always #4 core_clk = ~core_clk;
   // Core clock is exactly four times the undivided dedicated clock, the tightest case.
   always #16 wd_clk = ~wd_clk;
   iwr_watchdog iwr_watchdog_inst (.core_clk, .nrst, .clk_en(1'b1),
      .watchdog_dedicated_clock(wd_clk), .cfg, .refresh_cmd(cmd[0]), .status_read_command(cmd[1]),
      .clr_refresh_error(cmd[2]), .clr_underflow(cmd[3]), .status_word, .status_valid,
      .counting, .refresh_busy, .irq, .wd_reset);
   // Reports and counts a mismatch.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // One-cycle command pulse, launched just after an edge.
   task automatic pulse(input logic [3:0] m);
      @(posedge core_clk);
      cmd <= m;
      @(posedge core_clk);
      cmd <= 4'h0;
   endtask
   task automatic rd(output logic [15:0] w);
      pulse(4'h2);
      #1;
      check(status_valid, 1'b1);
      w = status_word;
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge core_clk);
   endtask
   // Bounded wait: 0 reload done, 1 interrupt, 2 reset pulse.
   // Starts 1 ns late so that outputs launched by the calling edge have settled.
   task automatic wait_for(input int s, input int lim);
      #1;
      n = 0;
      while (!(s == 0 ? !refresh_busy : s == 1 ? irq : wd_reset) && n < lim) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check(n < lim, 1'b1);
   endtask
   task automatic give_verdict;
      $display("compares %0d, bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Hang guard; the full run is about 90240 cycles.
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 98000) begin
         bad_count++;
         give_verdict;
      end
   end
   initial begin
      idle(2);
      nrst <= 1'b1;
      idle(20);
      #1;
      check(counting, 1'b0);
      rd(a);
      check(a, 16'h3FFF);
      pulse(4'h1);
      #1;
      check(refresh_busy, 1'b1);
      wait_for(0, 40);
      check(counting, 1'b1);
      rd(a);
      idle(40);
      rd(b);
      check((a - b) >= 9 && (a - b) <= 12, 1'b1);
      pulse(4'h1);
      wait_for(0, 40);
      rd(a);
      check(a[15:14], 2'b00);
      check(a >= 16'h3FFD, 1'b1);
      cfg.win_start <= WSTART_25;
      pulse(4'h1);
      idle(2);
      rd(a);
      rd(b);
      check(a[15], 1'b1);
      check(irq, 1'b1);
      pulse(4'h4);
      idle(2);
      check(b[15], 1'b1);
      rd(a);
      check({a[15], irq}, 2'b00);
      cfg.irq_en <= 1'b0;
      cfg.win_start <= WSTART_75;
      pulse(4'h1);
      wait_for(2, 20);
      check({wd_reset, irq}, 2'b10);
      pulse(4'h4);
      wait_for(0, 40);
      cfg.win_start <= WSTART_100;
      for (int i = 0; i < 5; i++) begin
         cfg.clk_div <= divs[i];
         idle(4 * ratio[i]);
         rd(a);
         idle(12 * ratio[i] - 2);
         rd(b);
         check((a - b) >= 2 && (a - b) <= 4, 1'b1);
      end
      // Let the count fall below the 75 percent end bound, then refresh too late.
      cfg.clk_div <= DIV_1;
      cfg.win_end <= WEND_75;
      idle(16600);
      pulse(4'h1);
      rd(a);
      check(a[15], 1'b1);
      pulse(4'h4);
      cfg.win_end <= WEND_0;
      cfg.irq_en <= 1'b1;
      wait_for(1, 70000);
      rd(a);
      check(a[15:14], 2'b01);
      pulse(4'h8);
      idle(2);
      check(irq, 1'b0);
      nrst <= 1'b0;
      cfg.auto_start <= 1'b1;
      idle(2);
      nrst <= 1'b1;
      idle(10);
      #1;
      check(counting, 1'b1);
      rd(a);
      check(a[15:14], 2'b00);
      give_verdict;
   end
endmodule
